// >>> mmd_consts.vh
/*
 Shared constants of the memory map decoder: special function register
 addresses, data memory areas, program bank layout and auxiliary RAM sizes.
 Assumes it is included by bare name from the decoder's design files.
*/
`ifndef MMD_CONSTS_VH
`define MMD_CONSTS_VH

`define MMD_SFR_PORT0_LATCH 8'h80
`define MMD_SFR_STACK_POINTER 8'h81
`define MMD_SFR_DATA_POINTER_LOW 8'h82
`define MMD_SFR_DATA_POINTER_HIGH 8'h83
`define MMD_SFR_EXTRA_INTERRUPT_ENABLE 8'h84
`define MMD_SFR_EXTRA_INTERRUPT_PRIORITY 8'h85
`define MMD_SFR_POWER_CONTROL 8'h87
`define MMD_SFR_TIMER_CONTROL 8'h88
`define MMD_SFR_TIMER_MODE 8'h89
`define MMD_SFR_TIMER0_COUNT_LOW 8'h8a
`define MMD_SFR_TIMER1_COUNT_LOW 8'h8b
`define MMD_SFR_TIMER0_COUNT_HIGH 8'h8c
`define MMD_SFR_TIMER1_COUNT_HIGH 8'h8d
`define MMD_SFR_PORT1_LATCH 8'h90
`define MMD_SFR_TIMER2_PERIOD_LOW 8'h91
`define MMD_SFR_PROGRAM_BANK_SELECT 8'he6

`define MMD_SFR_COUNT 16
`define MMD_SFR_INDEX_WIDTH 4
`define MMD_SFR_RESET 8'h00
`define MMD_BANK_SELECT_RESET 2'h0

`define MMD_SFR_SPACE_BASE 8'h80
`define MMD_REG_BANK_TOP 8'h1f
`define MMD_BIT_AREA_BASE 8'h20
`define MMD_BIT_AREA_TOP 8'h2f
`define MMD_LOWER_TOP 8'h7f
`define MMD_DATA_DEPTH 256
`define MMD_DATA_AW 8

`define MMD_REGION_REG_BANK 3'h0
`define MMD_REGION_BIT_AREA 3'h1
`define MMD_REGION_GENERAL 3'h2
`define MMD_REGION_UPPER 3'h3
`define MMD_REGION_SFR 3'h4

`define MMD_ROM_FLAT_BYTES 17'h10000
`define MMD_ROM_BANK_BYTES 17'h08000
`define MMD_ROM_BANK_COUNT 3

`define MMD_AUX_BYTES_OSD 16'h0800
`define MMD_AUX_BYTES_ONE_PAGE 16'h0c00
`define MMD_AUX_BYTES_TEN_PAGE 16'h3000
`define MMD_AUX_VARIANT_OSD 2'h0
`define MMD_AUX_VARIANT_ONE_PAGE 2'h1
`define MMD_AUX_VARIANT_TEN_PAGE 2'h2

`endif

// >>> mmd_data_ram.v
/*
 Internal data memory of 256 bytes with one write port and a registered read.
 Assumes address and write strobe come from logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "mmd_consts.vh"

module mmd_data_ram #(
    parameter AW = `MMD_DATA_AW,
    parameter DEPTH = `MMD_DATA_DEPTH
) (
    input wire clk_sys,
    input wire [AW-1:0] addr,
    input wire we,
    input wire [7:0] wdata,
    output reg [7:0] rdata_reg
);

reg [7:0] mem [0:DEPTH-1];

always @(posedge clk_sys)
begin
    if (we)
    begin
        mem[addr] <= wdata;
    end
    rdata_reg <= mem[addr];
end

endmodule // mmd_data_ram
`default_nettype wire

// >>> mmd_sfr_file.v
/*
 Special function registers held by the decoder, with a registered read.
 Assumes one access per cycle from the decoder; unheld addresses read zero.
*/
`timescale 1ns/10ps
`default_nettype none
`include "mmd_consts.vh"

module mmd_sfr_file (
    input wire clk_sys,
    input wire nrst,
    input wire [7:0] addr,
    input wire we,
    input wire [7:0] wdata,
    output reg [7:0] rdata_reg,
    output reg hit_reg,
    output wire [1:0] bank_select
);

reg [7:0] regs_reg [0:`MMD_SFR_COUNT-1];
reg [`MMD_SFR_INDEX_WIDTH-1:0] idx;
reg hit;
integer i;

always @*
begin
    hit = 1'b1;
    idx = 4'h0;
    case (addr)
        `MMD_SFR_PORT0_LATCH: idx = 4'h0;
        `MMD_SFR_STACK_POINTER: idx = 4'h1;
        `MMD_SFR_DATA_POINTER_LOW: idx = 4'h2;
        `MMD_SFR_DATA_POINTER_HIGH: idx = 4'h3;
        `MMD_SFR_EXTRA_INTERRUPT_ENABLE: idx = 4'h4;
        `MMD_SFR_EXTRA_INTERRUPT_PRIORITY: idx = 4'h5;
        `MMD_SFR_POWER_CONTROL: idx = 4'h6;
        `MMD_SFR_TIMER_CONTROL: idx = 4'h7;
        `MMD_SFR_TIMER_MODE: idx = 4'h8;
        `MMD_SFR_TIMER0_COUNT_LOW: idx = 4'h9;
        `MMD_SFR_TIMER1_COUNT_LOW: idx = 4'ha;
        `MMD_SFR_TIMER0_COUNT_HIGH: idx = 4'hb;
        `MMD_SFR_TIMER1_COUNT_HIGH: idx = 4'hc;
        `MMD_SFR_PORT1_LATCH: idx = 4'hd;
        `MMD_SFR_TIMER2_PERIOD_LOW: idx = 4'he;
        `MMD_SFR_PROGRAM_BANK_SELECT: idx = 4'hf;
        default: hit = 1'b0;
    endcase
end

assign bank_select = regs_reg[15][1:0]; // [R4]

always @(posedge clk_sys)
begin
    if (!nrst)
    begin
        for (i = 0; i < `MMD_SFR_COUNT; i = i + 1)
        begin
            regs_reg[i] <= `MMD_SFR_RESET; // [R13]
        end
        rdata_reg <= 8'h00;
        hit_reg <= 1'b0;
    end
    else
    begin
        if (we && hit)
        begin
            if (idx == 4'hf)
            begin
                regs_reg[idx] <= {6'h00, wdata[1:0]}; // [R4]
            end
            else
            begin
                regs_reg[idx] <= wdata;
            end
        end
        rdata_reg <= hit ? regs_reg[idx] : 8'h00;
        hit_reg <= hit;
    end
end

endmodule // mmd_sfr_file
`default_nettype wire

// >>> mmd_memory_map.v
/*
 Memory map decoder of the embedded 8-bit controller: program store mapping,
 internal data memory areas, special function register routing, bit access
 and auxiliary RAM range checking.
 Assumes the core drives all requests on clk_sys and issues a new data
 request only while busy_reg is low.
*/
//
// Contract
// [R1] The small program store is one flat 64K space with no banking.
// [R2] The 128K program store is four banks of 32K.
// [R3] One 32K bank is common and always addressable.
// [R4] Banks 0 to 2 are chosen one at a time by bits 1 and 0 of the bank select register.
// [R5] Data memory is 256 bytes and indirect access reaches all of it.
// [R6] Direct access below 80h goes to the lower half of data memory.
// [R7] Direct access at 80h and above goes to special function registers, indirect to memory.
// [R8] The lowest 32 bytes are four banks of eight working registers.
// [R9] The 16 bytes above the register banks are bit and byte addressable.
// [R10] The upper 128 bytes are plain storage.
// [R11] A special function register is bit addressable when its low nibble is 0h or 8h.
// [R12] Auxiliary RAM is 2K, 3K or 12K bytes depending on the version.
// [R13] After reset the bank select field reads zero.
`timescale 1ns/10ps
`default_nettype none
`include "mmd_consts.vh"

module mmd_memory_map #(
    parameter ROM_128K = 1,
    parameter [1:0] AUX_VARIANT = `MMD_AUX_VARIANT_TEN_PAGE
) (
    input wire clk_sys,
    input wire nrst,
    input wire code_req,
    input wire [15:0] code_addr,
    output reg [16:0] rom_addr_reg,
    output reg rom_valid_reg,
    output reg rom_bank_err_reg,
    input wire data_req,
    input wire data_indirect,
    input wire data_bit,
    input wire data_we,
    input wire [7:0] data_addr,
    input wire [7:0] data_wdata,
    input wire data_wbit,
    output reg busy_reg,
    output reg rd_valid_reg,
    output reg [7:0] rd_data_reg,
    output reg rd_bit_reg,
    output reg wr_done_reg,
    output reg [2:0] region_reg,
    output reg [2:0] reg_bank_reg,
    output reg sfr_bitable_reg,
    output reg sfr_miss_reg,
    output reg bit_err_reg,
    input wire aux_req,
    input wire [15:0] aux_addr,
    output reg aux_hit_reg,
    output reg aux_err_reg
);

localparam ST_IDLE = 3'b001;
localparam ST_READ = 3'b010;
localparam ST_MODIFY = 3'b100;

reg [2:0] state_reg;
reg [2:0] state_next;
reg to_sfr_reg;
reg is_write_reg;
reg is_bit_reg;
reg [2:0] bit_pos_reg;
reg wbit_reg;
reg [7:0] byte_addr_reg;

reg [7:0] tgt_addr;
reg tgt_sfr;
reg [2:0] tgt_bit;
reg [7:0] mod_byte;
reg [7:0] cur_byte;

wire [7:0] ram_q;
wire [7:0] sfr_q;
wire sfr_hit;
wire [1:0] bank_select;
wire start;
wire ram_we;
wire sfr_we;
wire [7:0] ram_addr;
wire [7:0] sfr_addr;
wire [7:0] wr_byte;

function bit_sfr;
    input [7:0] a;
    begin
        bit_sfr = a[7] && (a[3:0] == 4'h0 || a[3:0] == 4'h8); // [R11]
    end
endfunction

function [2:0] region_of;
    input [7:0] a;
    input sfr;
    begin
        if (sfr)
        begin
            region_of = `MMD_REGION_SFR; // [R7]
        end
        else if (a <= `MMD_REG_BANK_TOP)
        begin
            region_of = `MMD_REGION_REG_BANK; // [R8]
        end
        else if (a <= `MMD_BIT_AREA_TOP)
        begin
            region_of = `MMD_REGION_BIT_AREA; // [R9]
        end
        else if (a <= `MMD_LOWER_TOP)
        begin
            region_of = `MMD_REGION_GENERAL; // [R6]
        end
        else
        begin
            region_of = `MMD_REGION_UPPER; // [R10]
        end
    end
endfunction

// Target byte of the request: bit addresses below 80h land in the bit area,
// above it they select a bit addressable register.
always @*
begin
    tgt_bit = data_addr[2:0];
    if (data_bit)
    begin
        if (data_addr[7])
        begin
            tgt_addr = {data_addr[7:3], 3'h0}; // [R11]
            tgt_sfr = 1'b1;
        end
        else
        begin
            tgt_addr = `MMD_BIT_AREA_BASE + {4'h0, data_addr[6:3]}; // [R9]
            tgt_sfr = 1'b0;
        end
    end
    else
    begin
        tgt_addr = data_addr; // [R5]
        tgt_sfr = data_addr[7] && !data_indirect; // [R7]
    end
end

assign start = data_req && state_reg == ST_IDLE;

always @*
begin
    cur_byte = to_sfr_reg ? sfr_q : ram_q;
    mod_byte = cur_byte;
    mod_byte[bit_pos_reg] = wbit_reg;
end

assign wr_byte = state_reg == ST_MODIFY ? mod_byte : data_wdata;
assign ram_addr = start ? tgt_addr : byte_addr_reg; // [R5]
assign sfr_addr = start ? tgt_addr : byte_addr_reg;
assign ram_we = (start && data_we && !data_bit && !tgt_sfr)
    || (state_reg == ST_MODIFY && !to_sfr_reg);
assign sfr_we = (start && data_we && !data_bit && tgt_sfr)
    || (state_reg == ST_MODIFY && to_sfr_reg);

mmd_data_ram u_ram (
    .clk_sys(clk_sys),
    .addr(ram_addr),
    .we(ram_we),
    .wdata(wr_byte),
    .rdata_reg(ram_q)
);

mmd_sfr_file u_sfr (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .addr(sfr_addr),
    .we(sfr_we),
    .wdata(wr_byte),
    .rdata_reg(sfr_q),
    .hit_reg(sfr_hit),
    .bank_select(bank_select)
);

always @*
begin
    state_next = state_reg;
    case (state_reg)
        ST_IDLE:
        begin
            if (start && (!data_we || data_bit))
            begin
                state_next = ST_READ;
            end
        end
        ST_READ:
        begin
            state_next = (is_write_reg && is_bit_reg) ? ST_MODIFY : ST_IDLE;
        end
        ST_MODIFY:
        begin
            state_next = ST_IDLE;
        end
        default:
        begin
            state_next = ST_IDLE;
        end
    endcase
end

always @(posedge clk_sys)
begin
    if (!nrst)
    begin
        state_reg <= ST_IDLE;
        to_sfr_reg <= 1'b0;
        is_write_reg <= 1'b0;
        is_bit_reg <= 1'b0;
        bit_pos_reg <= 3'h0;
        wbit_reg <= 1'b0;
        byte_addr_reg <= 8'h00;
        busy_reg <= 1'b0;
        rd_valid_reg <= 1'b0;
        rd_data_reg <= 8'h00;
        rd_bit_reg <= 1'b0;
        wr_done_reg <= 1'b0;
        region_reg <= `MMD_REGION_REG_BANK;
        reg_bank_reg <= 3'h0;
        sfr_bitable_reg <= 1'b0;
        sfr_miss_reg <= 1'b0;
        bit_err_reg <= 1'b0;
    end
    else
    begin
        state_reg <= state_next;
        busy_reg <= state_next != ST_IDLE;
        rd_valid_reg <= 1'b0;
        wr_done_reg <= 1'b0;
        sfr_miss_reg <= 1'b0;
        bit_err_reg <= 1'b0;
        if (start)
        begin
            to_sfr_reg <= tgt_sfr;
            is_write_reg <= data_we;
            is_bit_reg <= data_bit;
            bit_pos_reg <= tgt_bit;
            wbit_reg <= data_wbit;
            byte_addr_reg <= tgt_addr;
            region_reg <= region_of(tgt_addr, tgt_sfr);
            reg_bank_reg <= {1'b0, tgt_addr[4:3]}; // [R8]
            sfr_bitable_reg <= tgt_sfr && bit_sfr(tgt_addr); // [R11]
            wr_done_reg <= data_we && !data_bit;
        end
        if (state_reg == ST_READ)
        begin
            sfr_miss_reg <= to_sfr_reg && !sfr_hit;
            bit_err_reg <= is_bit_reg && to_sfr_reg && !bit_sfr(byte_addr_reg); // [R11]
            if (!is_write_reg)
            begin
                rd_valid_reg <= 1'b1;
                rd_data_reg <= cur_byte;
                rd_bit_reg <= cur_byte[bit_pos_reg];
            end
        end
        if (state_reg == ST_MODIFY)
        begin
            wr_done_reg <= 1'b1;
        end
    end
end

// Program store mapping: with ROM_128K set, logical lower half is the common bank, upper half
// the switched bank placed after it in the physical store; otherwise one flat 64K space.
always @(posedge clk_sys)
begin
    if (!nrst)
    begin
        rom_addr_reg <= 17'h00000;
        rom_valid_reg <= 1'b0;
        rom_bank_err_reg <= 1'b0;
    end
    else
    begin
        rom_valid_reg <= code_req;
        rom_bank_err_reg <= 1'b0;
        if (code_req)
        begin
            if (ROM_128K == 0)
            begin
                rom_addr_reg <= {1'b0, code_addr}; // [R1]
            end
            else if (!code_addr[15])
            begin
                rom_addr_reg <= {2'h0, code_addr[14:0]}; // [R3]
            end
            else if (bank_select == 2'h3)
            begin
                rom_addr_reg <= {2'h1, code_addr[14:0]}; // [R4]
                rom_bank_err_reg <= 1'b1;
            end
            else
            begin
                rom_addr_reg <= {bank_select + 2'h1, code_addr[14:0]}; // [R2]
            end
        end
    end
end

// Auxiliary RAM range check for the chosen version.
wire [15:0] aux_limit;
assign aux_limit = AUX_VARIANT == `MMD_AUX_VARIANT_OSD ? `MMD_AUX_BYTES_OSD
    : AUX_VARIANT == `MMD_AUX_VARIANT_ONE_PAGE ? `MMD_AUX_BYTES_ONE_PAGE
    : `MMD_AUX_BYTES_TEN_PAGE; // [R12]

always @(posedge clk_sys)
begin
    if (!nrst)
    begin
        aux_hit_reg <= 1'b0;
        aux_err_reg <= 1'b0;
    end
    else
    begin
        aux_hit_reg <= aux_req && aux_addr < aux_limit; // [R12]
        aux_err_reg <= aux_req && aux_addr >= aux_limit;
    end
end

endmodule // mmd_memory_map
`default_nettype wire

// >>> mmd_memory_map_props.sv
/*
 Port checker of the memory map decoder.
 Assumes one clock and the synchronous active-low reset of the decoder.
*/
`timescale 1ns/10ps
`default_nettype none
module mmd_memory_map_props (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic code_req,
    input wire logic [15:0] code_addr,
    input wire logic [16:0] rom_addr_reg,
    input wire logic rom_valid_reg,
    input wire logic data_req,
    input wire logic data_indirect,
    input wire logic data_bit,
    input wire logic data_we,
    input wire logic [7:0] data_addr,
    input wire logic busy_reg,
    input wire logic rd_valid_reg,
    input wire logic wr_done_reg,
    input wire logic [2:0] region_reg,
    input wire logic sfr_bitable_reg,
    input wire logic aux_req,
    input wire logic aux_hit_reg,
    input wire logic aux_err_reg
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    wire tk = data_req && !busy_reg;
    wire byt = tk && !data_bit;
    sequence s_rd_done;
        busy_reg ##1 (rd_valid_reg && !busy_reg);
    endsequence
    sequence s_bw_done;
        busy_reg [*2] ##1 (wr_done_reg && !busy_reg);
    endsequence
    a_fetch_answer: assert property (
        code_req |=> rom_valid_reg) else $error("fetch not answered");
    a_common_bank: assert property (
        code_req && !code_addr[15] |=> rom_addr_reg == {2'h0, $past(code_addr[14:0])})
        else $error("common bank address wrong");
    a_read_walk: assert property (
        tk && !data_we |=> s_rd_done) else $error("read timing wrong");
    a_byte_write: assert property (
        byt && data_we |=> wr_done_reg && !busy_reg) else $error("byte write timing wrong");
    a_bit_write: assert property (
        tk && data_we && data_bit |=> s_bw_done) else $error("bit write timing wrong");
    a_sfr_route: assert property (
        byt && !data_indirect && data_addr[7] |=> region_reg == 3'h4)
        else $error("direct upper access not routed to registers");
    a_indirect_upper: assert property (
        byt && data_indirect && data_addr[7] |=> region_reg == 3'h3)
        else $error("indirect upper access not routed to memory");
    a_reg_bank_area: assert property (
        byt && data_addr[7:5] == 3'h0 |=> region_reg == 3'h0)
        else $error("register bank area wrong");
    a_bit_area: assert property (
        byt && data_addr[7:4] == 4'h2 |=> region_reg == 3'h1) else $error("bit area wrong");
    a_sfr_bitable: assert property (
        byt && !data_indirect && data_addr[7]
        |=> sfr_bitable_reg == ($past(data_addr[2:0]) == 3'h0)) else $error("bitable flag wrong");
    a_aux_answer: assert property (
        aux_req |=> aux_hit_reg != aux_err_reg) else $error("aux range answer wrong");
endmodule // mmd_memory_map_props
bind mmd_memory_map mmd_memory_map_props u_props (.clk_sys, .nrst, .code_req, .code_addr,
    .rom_addr_reg, .rom_valid_reg, .data_req, .data_indirect, .data_bit, .data_we, .data_addr,
    .busy_reg, .rd_valid_reg, .wr_done_reg, .region_reg, .sfr_bitable_reg, .aux_req,
    .aux_hit_reg, .aux_err_reg);
`default_nettype wire

// >>> mmd_memory_map_tb_top.sv
/*
 Self-checking bench of the memory map decoder.
 Assumes the decoder with its default parameters, a flat 64K OSD copy beside it, and a 100 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "mmd_consts.vh"
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin fail_count++; \
    $display("Error %s expected %h seen %h", n, e, a); end end
module mmd_memory_map_tb_top;
    logic clk_sys = 1'h0, nrst = 1'h0, code_req = 1'h0, data_req = 1'h0;
    logic data_indirect = 1'h0, data_bit = 1'h0, data_we = 1'h0, data_wbit = 1'h0;
    logic aux_req = 1'h0;
    logic [15:0] code_addr = 16'h0, aux_addr = 16'h0;
    logic [7:0] data_addr = 8'h0, data_wdata = 8'h0;
    wire [16:0] rom_addr_reg;
    wire [7:0] rd_data_reg;
    wire [2:0] region_reg, reg_bank_reg;
    wire rom_valid_reg, rom_bank_err_reg, busy_reg, rd_valid_reg, rd_bit_reg;
    wire wr_done_reg, sfr_bitable_reg, sfr_miss_reg, bit_err_reg, aux_hit_reg, aux_err_reg;
    wire [16:0] rom_addr_flat;
    wire aux_hit_flat;
    int fail_count = 0, num_checks = 0;
    logic [7:0] sfr_tab [15] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h87, 8'h88,
        8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h90, 8'h91};
    always #5 clk_sys = ~clk_sys;
    mmd_memory_map uut (.clk_sys, .nrst, .code_req, .code_addr, .rom_addr_reg, .rom_valid_reg,
        .rom_bank_err_reg, .data_req, .data_indirect, .data_bit, .data_we, .data_addr,
        .data_wdata, .data_wbit, .busy_reg, .rd_valid_reg, .rd_data_reg, .rd_bit_reg,
        .wr_done_reg, .region_reg, .reg_bank_reg, .sfr_bitable_reg, .sfr_miss_reg,
        .bit_err_reg, .aux_req, .aux_addr, .aux_hit_reg, .aux_err_reg);
    mmd_memory_map #(.ROM_128K(0), .AUX_VARIANT(`MMD_AUX_VARIANT_OSD)) uut_flat (.clk_sys,
        .nrst, .code_req, .code_addr, .rom_addr_reg(rom_addr_flat), .rom_valid_reg(),
        .rom_bank_err_reg(), .data_req, .data_indirect, .data_bit, .data_we, .data_addr,
        .data_wdata, .data_wbit, .busy_reg(), .rd_valid_reg(), .rd_data_reg(), .rd_bit_reg(),
        .wr_done_reg(), .region_reg(), .reg_bank_reg(), .sfr_bitable_reg(), .sfr_miss_reg(),
        .bit_err_reg(), .aux_req, .aux_addr, .aux_hit_reg(aux_hit_flat), .aux_err_reg());
    task end_of_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task fetch(input logic [15:0] a, input logic [16:0] e, input logic er);
        @(negedge clk_sys);
        code_req = 1'h1;
        code_addr = a;
        @(negedge clk_sys);
        code_req = 1'h0;
        `CHK("rom_valid", 1'h1, rom_valid_reg)
        `CHK("rom_addr", e, rom_addr_reg)
        `CHK("bank_err", er, rom_bank_err_reg)
        `CHK("rom_addr_flat", {1'h0, a}, rom_addr_flat)
    endtask
    task acc(input logic b, w, i, input logic [7:0] a, d);
        @(negedge clk_sys);
        data_bit = b;
        data_we = w;
        data_indirect = i;
        data_addr = a;
        data_wdata = d;
        data_wbit = d[0];
        data_req = 1'h1;
        @(negedge clk_sys);
        data_req = 1'h0;
        if (!w || b) @(negedge clk_sys);
        if (w && b) @(negedge clk_sys);
        if (w) `CHK("wr_done", 1'h1, wr_done_reg)
        else `CHK("rd_valid", 1'h1, rd_valid_reg)
    endtask
    task wr(input logic i, input logic [7:0] a, d);
        acc(1'h0, 1'h1, i, a, d);
    endtask
    task rd(input logic i, input logic [7:0] a, e, input logic [2:0] r);
        acc(1'h0, 1'h0, i, a, 8'h0);
        `CHK("rd_data", e, rd_data_reg)
        `CHK("region", r, region_reg)
        `CHK("bitable", !i && a[7] && a[2:0] == 3'h0, sfr_bitable_reg)
    endtask
    task aux(input logic [15:0] a, input logic h);
        @(negedge clk_sys);
        aux_req = 1'h1;
        aux_addr = a;
        @(negedge clk_sys);
        aux_req = 1'h0;
        `CHK("aux_hit", h, aux_hit_reg)
        `CHK("aux_err", !h, aux_err_reg)
        `CHK("aux_flat", a < `MMD_AUX_BYTES_OSD, aux_hit_flat)
    endtask
    initial
    begin
        repeat (16) @(negedge clk_sys);
        nrst = 1'h1;
        fetch(16'h8000, 17'h08000, 1'h0);
        fetch(16'h1234, 17'h01234, 1'h0);
        rd(1'h0, `MMD_SFR_PROGRAM_BANK_SELECT, 8'h00, 3'h4);
        foreach (sfr_tab[k])
            rd(1'h0, sfr_tab[k], 8'h00, 3'h4);
        wr(1'h0, 8'h81, 8'h3c);
        rd(1'h0, 8'h81, 8'h3c, 3'h4);
        `CHK("sfr_miss", 1'h0, sfr_miss_reg)
        for (int b = 0; b < 3; b++)
        begin
            wr(1'h0, `MMD_SFR_PROGRAM_BANK_SELECT, b[7:0]);
            fetch(16'h8abc, {b[1:0] + 2'h1, 15'h0abc}, 1'h0);
            fetch(16'h7abc, 17'h07abc, 1'h0);
        end
        wr(1'h0, `MMD_SFR_PROGRAM_BANK_SELECT, 8'hff);
        rd(1'h0, `MMD_SFR_PROGRAM_BANK_SELECT, 8'h03, 3'h4);
        fetch(16'hffff, 17'h0ffff, 1'h1);
        nrst = 1'h0;
        @(negedge clk_sys);
        nrst = 1'h1;
        fetch(16'h8000, 17'h08000, 1'h0);
        wr(1'h0, 8'h05, 8'ha5);
        rd(1'h0, 8'h05, 8'ha5, 3'h0);
        wr(1'h0, 8'h1b, 8'h3c);
        rd(1'h0, 8'h1b, 8'h3c, 3'h0);
        `CHK("reg_bank", 3'h3, reg_bank_reg)
        wr(1'h0, 8'h21, 8'h00);
        acc(1'h1, 1'h1, 1'h0, 8'h0a, 8'h01);
        rd(1'h0, 8'h21, 8'h04, 3'h1);
        acc(1'h1, 1'h0, 1'h0, 8'h0a, 8'h00);
        `CHK("rd_bit", 1'h1, rd_bit_reg)
        wr(1'h0, 8'h40, 8'h77);
        rd(1'h0, 8'h40, 8'h77, 3'h2);
        wr(1'h1, 8'hc0, 8'h5a);
        rd(1'h1, 8'hc0, 8'h5a, 3'h3);
        rd(1'h0, 8'hc0, 8'h00, 3'h4);
        `CHK("sfr_miss", 1'h1, sfr_miss_reg)
        wr(1'h1, 8'hff, 8'hc3);
        rd(1'h1, 8'hff, 8'hc3, 3'h3);
        acc(1'h1, 1'h1, 1'h0, 8'h93, 8'h01);
        rd(1'h0, 8'h90, 8'h08, 3'h4);
        acc(1'h1, 1'h0, 1'h0, 8'h93, 8'h00);
        `CHK("rd_bit", 1'h1, rd_bit_reg)
        `CHK("bit_err", 1'h0, bit_err_reg)
        aux(`MMD_AUX_BYTES_OSD - 16'h1, 1'h1);
        aux(`MMD_AUX_BYTES_TEN_PAGE - 16'h1, 1'h1);
        aux(`MMD_AUX_BYTES_TEN_PAGE, 1'h0);
        end_of_test;
    end
    initial
    begin
        repeat (2000) @(posedge clk_sys);
        fail_count++;
        end_of_test;
    end
endmodule // mmd_memory_map_tb_top
`default_nettype wire
